// [logic/self_id_pkg.sv]
// Package: register map, field layout and stream types of the self-ID capture block
package self_id_pkg;
	localparam logic [7:0]  LINK_CONTROL_OFS = 8'h08;
	localparam logic [7:0]  IRQ_STATUS_OFS   = 8'h0C;
	localparam logic [7:0]  IRQ_MASK_OFS     = 8'h10;
	localparam logic [7:0]  CAPTURE_STAT_OFS = 8'h14;
	localparam int          RX_ENABLE_BIT    = 1;
	localparam int          FULL_CAPTURE_BIT = 2;
	localparam int          RESUME_SEEN_BIT  = 3;
	localparam logic [31:0] LINK_CONTROL_RST = 32'h0000_0000;
	localparam logic [31:0] SID_HEADER_Q     = 32'h0000_00E0;
	localparam logic [3:0]  ACK_COMPLETE     = 4'h1;
	localparam logic [3:0]  ACK_DATA_ERROR   = 4'hD;
	localparam logic [3:0]  RESUME_TYPE      = 4'hF;
	localparam int          ACK_LSB          = 16;
	localparam int          EXT_TYPE_LSB     = 18;
	localparam int          PHY_ID_LSB       = 24;
	localparam logic [1:0]  SID_TAG          = 2'h2;
	localparam logic [1:0]  EXT_TAG          = 2'h0;
	localparam logic [1:0]  AXI_OKAY         = 2'h0;
	localparam logic [1:0]  AXI_SLVERR       = 2'h2;
	// Interrupt status bits
	localparam int          IRQ_SEQ_DONE     = 0;
	localparam int          IRQ_SEQ_ERR      = 1;
	localparam int          IRQ_RESUME       = 2;
	localparam int          IRQ_DROP         = 3;
	localparam int          IRQ_BITS         = 4;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} quad_t;

	typedef enum {CAP_IDLE, CAP_DATA, CAP_INV, CAP_HDR, CAP_ACK} cap_state_t;

	function automatic logic isResume(input logic [31:0] q);
		return q[31:30] == EXT_TAG && q[EXT_TYPE_LSB +: 4] == RESUME_TYPE;
	endfunction
endpackage

// [logic/self_id_receive_capture.sv]
// Self-ID packet capture from the physical-layer receive stream into the general receive FIFO
`timescale 1ns/10ps
// Notes on behaviour
// - Control word at 08h: bit 1 enables self-ID capture, bit 2 selects full capture.
// - Enable clear: every self-ID packet dropped, nothing written to the FIFO.
// - Enable set, full clear: only each packet's first data quadlet is stored.
// - Both set: data quadlet and following inverse quadlet are both stored.
// - Stored sequence starts with header 0000_00E0h and ends with acknowledge quadlet.
// - Acknowledge field is 0001 when data correct, other value otherwise.
// - Single node: FIFO receives only header and acknowledge quadlets.
// - Full capture: header, each data and inverse in arrival order, then acknowledge.
// - Resume packet is an extended packet with type field F.
// - Resume packet node field names the source node.
module self_id_receive_capture
	import self_id_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Physical-layer receive stream
	input  wire logic        rxValid,
	input  wire logic [31:0] rxQuad,
	input  wire logic        rxSidBegin,
	input  wire logic        rxSidEnd,
	// General receive FIFO write port
	output logic             fifoWrite,
	output logic [31:0]      fifoData,
	input  wire logic        fifoFull,
	// Resume source report
	output logic [5:0]       resumeNode,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Interrupt
	output logic             irq
);

	//----------------------------------------
	// Reset release
	//----------------------------------------
	logic rstMeta_r;
	logic rstSync_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end
	wire rstN = rstSync_r;

	//----------------------------------------
	// Registers
	//----------------------------------------
	logic [31:0]         linkControl_r;
	logic [IRQ_BITS-1:0] irqStatus_r;
	logic [IRQ_BITS-1:0] irqMask_r;
	logic [IRQ_BITS-1:0] irqSet;
	logic [7:0]          lastCount_r;
	logic [3:0]          lastAck_r;

	wire rxEnable    = linkControl_r[RX_ENABLE_BIT];
	wire fullCapture = linkControl_r[FULL_CAPTURE_BIT];

	// Write path: address and data accepted separately, in any order
	logic [7:0]  awAddr_r;
	logic [31:0] wData_r;
	logic [3:0]  wStrb_r;
	logic        awHeld_r;
	logic        wHeld_r;
	wire         doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r  <= 32'h0000_0000;
			wStrb_r  <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= AXI_OKAY;
		end else begin
			s_axi_awready <= !awHeld_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !wHeld_r && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_r     <= 1'b0;
				wHeld_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr_r == LINK_CONTROL_OFS || awAddr_r == IRQ_STATUS_OFS
					|| awAddr_r == IRQ_MASK_OFS) ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[8*i +: 8] = nw[8*i +: 8];
		end
		return res;
	endfunction

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			linkControl_r <= LINK_CONTROL_RST;
			irqMask_r     <= '0;
		end else if (doWrite) begin
			if (awAddr_r == LINK_CONTROL_OFS)
				linkControl_r <= mergeBytes(linkControl_r, wData_r, wStrb_r);
			if (awAddr_r == IRQ_MASK_OFS && wStrb_r[0])
				irqMask_r <= wData_r[IRQ_BITS-1:0];
		end
	end

	wire [IRQ_BITS-1:0] irqClr = (doWrite && awAddr_r == IRQ_STATUS_OFS && wStrb_r[0])
		? wData_r[IRQ_BITS-1:0] : '0;

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			irqStatus_r <= '0;
			irq         <= 1'b0;
		end else begin
			irqStatus_r <= (irqStatus_r & ~irqClr) | irqSet;
			irq         <= |(((irqStatus_r & ~irqClr) | irqSet) & irqMask_r);
		end
	end

	// Read path
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= AXI_OKAY;
				case (s_axi_araddr)
					LINK_CONTROL_OFS: s_axi_rdata <= linkControl_r;
					IRQ_STATUS_OFS:   s_axi_rdata <= {{(32-IRQ_BITS){1'b0}}, irqStatus_r};
					IRQ_MASK_OFS:     s_axi_rdata <= {{(32-IRQ_BITS){1'b0}}, irqMask_r};
					CAPTURE_STAT_OFS: s_axi_rdata <= {20'h00000, lastAck_r, lastCount_r};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= AXI_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	//----------------------------------------
	// Self-ID capture
	//----------------------------------------
	cap_state_t  state_r;
	logic        keep_r;
	logic        keepFull_r;
	logic        seqErr_r;
	logic [31:0] dataQ_r;
	logic [7:0]  count_r;
	quad_t       out;

	// Quadlet offered to the FIFO in this cycle
	always_comb begin
		out = '{valid: 1'b0, data: 32'h0000_0000};
		case (state_r)
			CAP_IDLE: if (rxSidBegin && rxEnable)
				out = '{valid: 1'b1, data: SID_HEADER_Q};
			CAP_DATA: if (!rxSidEnd && rxValid && keep_r)
				out = '{valid: 1'b1, data: rxQuad};
			CAP_INV: if (!rxSidEnd && rxValid && keep_r && keepFull_r)
				out = '{valid: 1'b1, data: rxQuad};
			CAP_ACK: if (keep_r)
				out = '{valid: 1'b1,
					data: {12'h000, seqErr_r ? ACK_DATA_ERROR : ACK_COMPLETE, 16'h0000}};
			default: out = '{valid: 1'b0, data: 32'h0000_0000};
		endcase
	end

	// Mode is latched at sequence start so a mid-sequence write cannot split the record
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			state_r     <= CAP_IDLE;
			keep_r      <= 1'b0;
			keepFull_r  <= 1'b0;
			seqErr_r    <= 1'b0;
			dataQ_r     <= 32'h0000_0000;
			count_r     <= 8'h00;
			lastCount_r <= 8'h00;
			lastAck_r   <= 4'h0;
			fifoWrite   <= 1'b0;
			fifoData    <= 32'h0000_0000;
			irqSet      <= '0;
		end else begin
			irqSet     <= '0;
			case (state_r)
				CAP_IDLE: if (rxSidBegin) begin
					keep_r     <= rxEnable;
					keepFull_r <= fullCapture;
					seqErr_r   <= 1'b0;
					count_r    <= 8'h00;
					if (rxEnable) begin
						count_r <= 8'h01;
					end else begin
						irqSet[IRQ_DROP] <= 1'b1;
					end
					state_r <= CAP_DATA;
				end
				CAP_DATA: if (rxSidEnd) begin
					state_r <= CAP_ACK;
				end else if (rxValid) begin
					dataQ_r <= rxQuad;
					state_r <= CAP_INV;
				end
				CAP_INV: if (rxSidEnd) begin
					seqErr_r <= 1'b1;
					state_r  <= CAP_ACK;
				end else if (rxValid) begin
					if (rxQuad != ~dataQ_r)
						seqErr_r <= 1'b1;
					state_r <= CAP_DATA;
				end
				CAP_ACK: begin
					if (keep_r) begin
						lastAck_r   <= seqErr_r ? ACK_DATA_ERROR : ACK_COMPLETE;
						lastCount_r <= count_r + 8'h01;
						irqSet[IRQ_SEQ_DONE] <= 1'b1;
						irqSet[IRQ_SEQ_ERR]  <= seqErr_r;
					end
					state_r <= CAP_IDLE;
				end
				default: state_r <= CAP_IDLE;
			endcase
			if (out.valid && state_r != CAP_IDLE && state_r != CAP_ACK)
				count_r <= count_r + 8'h01;
			if (out.valid && fifoFull)
				seqErr_r <= 1'b1;
			fifoWrite <= out.valid && !fifoFull;
			fifoData  <= out.data;
			if (state_r == CAP_IDLE && rxValid && isResume(rxQuad))
				irqSet[IRQ_RESUME] <= 1'b1;
		end
	end

	// Resume source node
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN)
			resumeNode <= 6'h00;
		else if (state_r == CAP_IDLE && rxValid && isResume(rxQuad))
			resumeNode <= rxQuad[PHY_ID_LSB +: 6];
	end

	//----------------------------------------
	// Checks
	//----------------------------------------
	disabled_drop_a: assert property (@(posedge mclk) disable iff (!rstN)
		(state_r != CAP_IDLE && !keep_r) |=> !fifoWrite)
		else $error("write while capture disabled");
	header_first_a: assert property (@(posedge mclk) disable iff (!rstN)
		(state_r == CAP_IDLE && rxSidBegin && rxEnable && !fifoFull) |=> fifoWrite && fifoData == SID_HEADER_Q)
		else $error("header quadlet missing");
	data_only_a: assert property (@(posedge mclk) disable iff (!rstN)
		(state_r == CAP_INV && rxValid && !rxSidEnd && !keepFull_r) |=> !fifoWrite)
		else $error("inverse stored in data-only mode");
	full_inv_a: assert property (@(posedge mclk) disable iff (!rstN)
		(state_r == CAP_INV && rxValid && !rxSidEnd && keep_r && keepFull_r && !fifoFull)
		|=> fifoWrite && fifoData == $past(rxQuad))
		else $error("inverse quadlet not stored");
	data_order_a: assert property (@(posedge mclk) disable iff (!rstN)
		(state_r == CAP_DATA && rxValid && !rxSidEnd && keep_r && !fifoFull)
		|=> fifoWrite && fifoData == $past(rxQuad))
		else $error("data quadlet not stored in order");
	ack_last_a: assert property (@(posedge mclk) disable iff (!rstN)
		(state_r == CAP_ACK && keep_r && !fifoFull) |=> fifoWrite && fifoData[ACK_LSB +: 4] == lastAck_r ##1 !fifoWrite)
		else $error("acknowledge quadlet not last");
	ack_code_a: assert property (@(posedge mclk) disable iff (!rstN)
		(state_r == CAP_ACK && keep_r) |=> (lastAck_r == ACK_COMPLETE) == !$past(seqErr_r))
		else $error("acknowledge code wrong");
	single_node_a: assert property (@(posedge mclk) disable iff (!rstN)
		(state_r == CAP_DATA && rxSidEnd) |=> state_r == CAP_ACK)
		else $error("empty sequence not closed");
	irq_level_a: assert property (@(posedge mclk) disable iff (!rstN)
		(irqSet & irqMask_r) != '0 |=> irq)
		else $error("interrupt not raised");
endmodule

// [verif/phy_sid_source.sv]
// Behavioural physical-layer device feeding self-ID and resume packets
`timescale 1ns/10ps
module phy_sid_source (
	// Clock
	input  wire logic   mclk,
	// Stream towards the link
	output logic        rxValid,
	output logic [31:0] rxQuad,
	output logic        rxSidBegin,
	output logic        rxSidEnd
);
	initial begin
		rxValid = 1'b0;
		rxQuad = 32'hA5A5_A5A5;
		rxSidBegin = 1'b0;
		rxSidEnd = 1'b0;
	end

	function automatic logic [31:0] sidQuad(input int i);
		return {2'h2, i[5:0], 24'h8C_C4F3};
	endfunction

	// --------------------------------------------------------------
	// Self-ID sequence, data and inverse back to back
	// --------------------------------------------------------------
	task automatic sendSeq(input int n, input logic breakInv);
		@(posedge mclk);
		rxSidBegin <= 1'b1;
		@(posedge mclk);
		rxSidBegin <= 1'b0;
		for (int i = 0; i < n; i++) begin
			rxValid <= 1'b1;
			rxQuad <= sidQuad(i);
			@(posedge mclk);
			rxQuad <= (breakInv && i == n - 1) ? sidQuad(i) : ~sidQuad(i);
			@(posedge mclk);
		end
		rxValid <= 1'b0;
		rxQuad <= ~rxQuad;
		rxSidEnd <= 1'b1;
		@(posedge mclk);
		rxSidEnd <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	task automatic sendResume(input logic [5:0] id);
		@(posedge mclk);
		rxValid <= 1'b1;
		rxQuad <= {2'h0, id, 2'h0, 4'hF, 18'h0_0000};
		@(posedge mclk);
		rxValid <= 1'b0;
		rxQuad <= ~rxQuad;
	endtask
endmodule

// [verif/self_id_receive_capture_bench.sv]
// Self-checking bench for the self-ID capture block
`timescale 1ns/10ps
module self_id_receive_capture_bench
	import self_id_pkg::*;
;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        rxValid, rxSidBegin, rxSidEnd, fifoWrite, irq;
	logic        fifoFull = 1'b0;
	logic [31:0] rxQuad, fifoData, s_axi_rdata, rd;
	logic [5:0]  resumeNode;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
	logic [31:0] got[$];
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cycles = 0;

	self_id_receive_capture u_dut (
		.mclk          (mclk),
		.arst_n        (arst_n),
		.rxValid       (rxValid),
		.rxQuad        (rxQuad),
		.rxSidBegin    (rxSidBegin),
		.rxSidEnd      (rxSidEnd),
		.fifoWrite     (fifoWrite),
		.fifoData      (fifoData),
		.fifoFull      (fifoFull),
		.resumeNode    (resumeNode),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.irq           (irq)
	);
	phy_sid_source u_phy (
		.mclk       (mclk),
		.rxValid    (rxValid),
		.rxQuad     (rxQuad),
		.rxSidBegin (rxSidBegin),
		.rxSidEnd   (rxSidEnd)
	);

	always #12.5 mclk = ~mclk;

	// Collects FIFO writes; ceiling far above the run's length
	always @(posedge mclk) begin
		cycles++;
		if (fifoWrite === 1'b1)
			got.push_back(fifoData);
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	// --------------------------------------------------------------
	// Bus and compare tasks
	// --------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// One edge between calls so no strobe is lowered and raised at once
		@(posedge mclk);
	endtask

	task automatic axiRead(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic runSeq(input int n, input logic bad, input logic en, input logic full);
		logic [31:0] want[$];
		got.delete();
		if (en) begin
			want.push_back(SID_HEADER_Q);
			for (int i = 0; i < n; i++) begin
				want.push_back(u_phy.sidQuad(i));
				if (full)
					want.push_back((bad && i == n - 1) ? u_phy.sidQuad(i) : ~u_phy.sidQuad(i));
			end
			want.push_back({12'h000, bad ? ACK_DATA_ERROR : ACK_COMPLETE, 16'h0000});
		end
		u_phy.sendSeq(n, bad);
		repeat (4) @(posedge mclk);
		check(got.size() == want.size(), "stored quadlet count");
		foreach (want[i])
			if (i < got.size())
				check(got[i] === want[i], "stored quadlet");
		axiRead(CAPTURE_STAT_OFS);
		if (en)
			check(rd === {20'h00000, bad ? ACK_DATA_ERROR : ACK_COMPLETE, 8'(want.size())}, "capture status");
	endtask

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		axiRead(LINK_CONTROL_OFS);
		check(rd === LINK_CONTROL_RST, "control reset value");
		axiRead(8'h40);
		check(rr === AXI_SLVERR && rd === 32'h0000_0000, "unmapped read");
		axiWrite(LINK_CONTROL_OFS, 32'h0000_0006);
		check(br === AXI_OKAY, "control write response");
		axiWrite(CAPTURE_STAT_OFS, 32'h0000_00FF);
		check(br === AXI_SLVERR, "read-only write refused");
		axiRead(LINK_CONTROL_OFS);
		check(rd === 32'h0000_0006, "control readback");
		for (int m = 0; m < 4; m++) begin
			axiWrite(LINK_CONTROL_OFS, 32'(m) << 1);
			runSeq(3, 1'b0, m[0], m[1]);
		end
		runSeq(0, 1'b0, 1'b1, 1'b1);
		runSeq(1, 1'b0, 1'b1, 1'b1);
		$display("test capture modes done");
		axiWrite(IRQ_STATUS_OFS, 32'h0000_000F);
		axiWrite(IRQ_MASK_OFS, 32'h0000_0000);
		runSeq(2, 1'b1, 1'b1, 1'b1);
		axiRead(IRQ_STATUS_OFS);
		check(rd === 32'((1 << IRQ_SEQ_DONE) | (1 << IRQ_SEQ_ERR)) && irq === 1'b0, "masked error status");
		axiWrite(IRQ_MASK_OFS, 32'(1 << IRQ_SEQ_ERR));
		repeat (2) @(posedge mclk);
		check(irq === 1'b1, "interrupt raised");
		axiWrite(IRQ_STATUS_OFS, 32'(1 << IRQ_SEQ_ERR));
		repeat (2) @(posedge mclk);
		axiRead(IRQ_STATUS_OFS);
		check(irq === 1'b0 && rd[IRQ_SEQ_ERR] === 1'b0, "interrupt cleared");
		$display("test interrupt done");
		got.delete();
		fifoFull <= 1'b1;
		u_phy.sendSeq(1, 1'b0);
		fifoFull <= 1'b0;
		axiRead(CAPTURE_STAT_OFS);
		check(got.size() == 0 && rd[8 +: 4] === ACK_DATA_ERROR, "full FIFO flagged");
		$display("test full FIFO done");
		got.delete();
		u_phy.sendResume(6'h2A);
		repeat (3) @(posedge mclk);
		check(resumeNode === 6'h2A && got.size() == 0, "resume source node");
		axiRead(IRQ_STATUS_OFS);
		check(rd[IRQ_RESUME] === 1'b1, "resume flagged");
		$display("test resume done");
		give_verdict();
	end
endmodule
